// [rtl/expander_pkg.sv]
/*
  Shared constants and types for the four-port expander register block.
  Assumes a single 40 MHz clock domain; pins are synchronised in the block.
*/
package expander_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_RSVD_LOW = 8'h00;
  localparam logic [7:0] ADDR_PORT_FIRST = 8'h01;
  localparam logic [7:0] ADDR_PORT_LAST = 8'h04;
  localparam logic [7:0] ADDR_CFG_FLAGS = 8'h26;
  localparam logic [7:0] ADDR_CFG_FUNC = 8'h27;
  localparam logic [7:0] ADDR_RSVD_HIGH_FIRST = 8'h3c;
  localparam logic [7:0] ADDR_RSVD_HIGH_LAST = 8'h3f;
  // Reset and fixed read values
  localparam logic [7:0] PORT_RESET = 8'h80;
  localparam logic [7:0] CFG_FLAGS_RESET = 8'hec;
  localparam logic [7:0] CFG_FUNC_RESET = 8'h8f;
  localparam logic [7:0] RSVD_LOW_VALUE = 8'h80;
  localparam logic [7:0] RSVD_HIGH_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // Function register: bits D6..D4 read as zero
  localparam logic [7:0] CFG_FUNC_WR_MASK = 8'h8f;
  // Function register bit positions, 1 = port used as plain I/O
  localparam int FUNC_P1_GPIO = 1;
  localparam int FUNC_P2_GPIO = 2;
  localparam int FUNC_P3_GPIO = 3;
  // Port indices
  localparam int P1_IDX = 0;
  localparam int P2_IDX = 1;
  localparam int P3_IDX = 2;
  localparam int NUM_PORTS = 4;
  // Serial link figures
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h4c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Port register: input view (b6 supply ref, b5 irq enable, low[2] debounce)
  // output view (b6 push-pull, b5 blink, low duty)
  typedef struct packed {
    logic is_input;
    logic mode_b6;
    logic mode_b5;
    logic [4:0] low;
  } port_reg_t;

  // Writable part of the flags register
  typedef struct packed {
    logic [3:0] blink_sel;
    logic tmr_clr;
    logic por_clr;
  } flags_cfg_t;

  // Pins passing through the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic rst_n;
    logic [3:0] port;
  } pins_t;

  localparam pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, rst_n: 1'b1, port: 4'h0};

  // Serial slave states
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK} i2c_state_t;
endpackage

// [rtl/four_port_expander_regs.sv]
/*
  Four-port expander: serial slave, register bank, transition flags,
  reset-pin options, blink counter and port pin drivers.
  Assumes SCL, SDA, the reset pin and port inputs are asynchronous pins.
*/
`timescale 1ns/1ps
// Overview of operation
// - Ports come up as inputs
// - Interrupt status flag starts inactive high
// - One port register each at 0x01..0x04
// - Pointer auto-increments; 0x05, 0x28 empty
// - Port registers reset to 0x80
// - Flags register resets to 0xec
// - Function register resets to 0x8f
// - D7 low after enabled port interrupt
// - D6 low after any input transition
// - Timer bit lets reset pin clear blink counter
// - POR bit lets reset pin restore registers
// - Prescaler bits choose global blink rate
// - First port open-drain only, others push-pull when D6 set
// - Function D1 low makes first port interrupt
// - Port D5 enables its transition interrupt
// - Port D1 shows transition since last read
module four_port_expander_regs #(
  parameter logic [6:0] SLAVE_ADDR = expander_pkg::SLAVE_ADDR_DEFAULT,
  parameter int BLINK_BASE = 13,
  parameter int BLINK_W = BLINK_BASE + 16
) (
  // Clock and power-on reset
  input wire logic CLK,
  input wire logic RST_N,
  // Serial link
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Reset pin
  input wire logic RESET_PIN_N,
  // Port pins
  input wire logic [3:0] PORT_IN,
  output logic [3:0] PORT_OUT,
  output logic [3:0] PORT_OE
);
  // Synchroniser stages; s3 only serves edge detection
  expander_pkg::pins_t s1_q, s2_q, s3_q;
  // Serial slave state
  expander_pkg::i2c_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d; // Bit counter
  logic [7:0] sh_q, sh_d; // Shift register
  logic [7:0] ptr_q, ptr_d; // Register pointer
  logic rw_q, rw_d; // Read requested
  logic ack_ok_q, ack_ok_d; // Master acknowledged
  logic sda_oe_q, sda_oe_d; // Pull SDA low
  // Register bank
  expander_pkg::port_reg_t port_q [expander_pkg::NUM_PORTS];
  expander_pkg::port_reg_t port_d [expander_pkg::NUM_PORTS];
  expander_pkg::flags_cfg_t flags_q, flags_d;
  logic [7:0] func_q, func_d;
  logic [3:0] trans_q, trans_d; // Per-port transition seen
  logic tflag_q, tflag_d; // Any transition seen
  logic [BLINK_W-1:0] blink_q, blink_d;
  // Pin drivers
  logic [3:0] out_q, out_d, oe_q, oe_d;
  // Decoded events
  logic scl_rise, scl_fall, start, stop, pin_ev;
  logic [3:0] trans_ev;
  logic irq_pend, phase, level;
  logic rd_now, wr_now;
  logic [1:0] pidx;
  logic [7:0] rd_data, flags_rd;

  // Two-stage synchroniser plus edge history
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s1_q <= expander_pkg::PINS_IDLE;
      s2_q <= expander_pkg::PINS_IDLE;
      s3_q <= expander_pkg::PINS_IDLE;
    end
    else
    begin
      s1_q <= '{scl: SCL, sda: SDA_IN, rst_n: RESET_PIN_N, port: PORT_IN};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge and condition decode from settled samples
  assign scl_rise = s2_q.scl && !s3_q.scl;
  assign scl_fall = !s2_q.scl && s3_q.scl;
  assign start = s2_q.scl && s3_q.scl && !s2_q.sda && s3_q.sda;
  assign stop = s2_q.scl && s3_q.scl && s2_q.sda && !s3_q.sda;
  assign pin_ev = !s2_q.rst_n && s3_q.rst_n;
  // Input-mode level changes only
  always_comb
  begin
    for (int k = 0; k < expander_pkg::NUM_PORTS; k++)
      trans_ev[k] = port_q[k].is_input && (s2_q.port[k] != s3_q.port[k]);
  end
  // Enabled transitions raise the interrupt
  // Only ports in input mode count; in output mode D5 selects blink
  assign irq_pend = |(trans_q & {port_q[3].mode_b5 & port_q[3].is_input, port_q[2].mode_b5 & port_q[2].is_input,
    port_q[1].mode_b5 & port_q[1].is_input, port_q[0].mode_b5 & port_q[0].is_input});
  // Global blink phase picked by prescaler
  assign phase = blink_q[BLINK_BASE + int'(flags_q.blink_sel)];

  // Read multiplexer
  always_comb
  begin
    pidx = 2'(ptr_q - expander_pkg::ADDR_PORT_FIRST);
    flags_rd = {!irq_pend, !tflag_q, flags_q};
    if (ptr_q >= expander_pkg::ADDR_PORT_FIRST && ptr_q <= expander_pkg::ADDR_PORT_LAST)
    begin
      // Input view shows transition and live level
      if (port_q[pidx].is_input)
        rd_data = {port_q[pidx][7:2], trans_q[pidx], s2_q.port[pidx]};
      else
        rd_data = port_q[pidx];
    end
    else if (ptr_q == expander_pkg::ADDR_CFG_FLAGS)
      rd_data = flags_rd;
    else if (ptr_q == expander_pkg::ADDR_CFG_FUNC)
      rd_data = func_q;
    else if (ptr_q == expander_pkg::ADDR_RSVD_LOW)
      rd_data = expander_pkg::RSVD_LOW_VALUE;
    else if (ptr_q >= expander_pkg::ADDR_RSVD_HIGH_FIRST && ptr_q <= expander_pkg::ADDR_RSVD_HIGH_LAST)
      rd_data = expander_pkg::RSVD_HIGH_VALUE;
    else
      rd_data = expander_pkg::UNMAPPED_VALUE; // Empty slots such as 0x05, 0x28
  end

  // Serial slave and register bank next state
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    ack_ok_d = ack_ok_q;
    sda_oe_d = sda_oe_q;
    port_d = port_q;
    flags_d = flags_q;
    func_d = func_q;
    trans_d = trans_q;
    tflag_d = tflag_q;
    blink_d = blink_q + BLINK_W'(1);
    rd_now = 1'b0;
    wr_now = 1'b0;
    // Frame control; reset pin low frees the link
    if (start)
    begin
      st_d = expander_pkg::S_ADDR;
      cnt_d = '0;
      sda_oe_d = 1'b0;
    end
    else if (stop || !s2_q.rst_n)
    begin
      st_d = expander_pkg::S_IDLE;
      sda_oe_d = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_q)
        // Sample incoming bits
        expander_pkg::S_ADDR, expander_pkg::S_REG, expander_pkg::S_WR:
        begin
          sh_d = {sh_q[6:0], s2_q.sda};
          cnt_d = cnt_q + 4'h1;
        end
        // Count outgoing bits
        expander_pkg::S_RD:
          cnt_d = cnt_q + 4'h1;
        // Master acknowledge is SDA low
        expander_pkg::S_RD_ACK:
          ack_ok_d = !s2_q.sda;
        default:
          cnt_d = cnt_q;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_q)
        // Slave address match
        expander_pkg::S_ADDR:
          if (cnt_q == expander_pkg::BITS_PER_BYTE)
          begin
            if (sh_q[7:1] == SLAVE_ADDR)
            begin
              st_d = expander_pkg::S_ADDR_ACK;
              rw_d = sh_q[0];
              sda_oe_d = 1'b1;
            end
            else
              st_d = expander_pkg::S_IDLE;
          end
        // Register address byte
        expander_pkg::S_REG:
          if (cnt_q == expander_pkg::BITS_PER_BYTE)
          begin
            ptr_d = sh_q;
            st_d = expander_pkg::S_REG_ACK;
            sda_oe_d = 1'b1;
          end
        // Data byte written, pointer advances
        expander_pkg::S_WR:
          if (cnt_q == expander_pkg::BITS_PER_BYTE)
          begin
            wr_now = 1'b1;
            ptr_d = ptr_q + 8'h01;
            st_d = expander_pkg::S_WR_ACK;
            sda_oe_d = 1'b1;
          end
        // After own ack, writes continue
        expander_pkg::S_REG_ACK, expander_pkg::S_WR_ACK:
        begin
          st_d = expander_pkg::S_WR;
          cnt_d = '0;
          sda_oe_d = 1'b0;
        end
        // Shift out, release after eighth bit
        expander_pkg::S_RD:
          if (cnt_q == expander_pkg::BITS_PER_BYTE)
          begin
            st_d = expander_pkg::S_RD_ACK;
            sda_oe_d = 1'b0;
          end
          else
          begin
            sh_d = {sh_q[6:0], 1'b0};
            sda_oe_d = !sh_q[6];
          end
        // Load a read byte or end/turn the frame
        expander_pkg::S_ADDR_ACK, expander_pkg::S_RD_ACK:
          if ((st_q == expander_pkg::S_ADDR_ACK && rw_q) || (st_q == expander_pkg::S_RD_ACK && ack_ok_q))
          begin
            rd_now = 1'b1;
            sh_d = rd_data;
            ptr_d = ptr_q + 8'h01;
            cnt_d = '0;
            st_d = expander_pkg::S_RD;
            sda_oe_d = !rd_data[7];
          end
          else if (st_q == expander_pkg::S_ADDR_ACK)
          begin
            st_d = expander_pkg::S_REG;
            cnt_d = '0;
            sda_oe_d = 1'b0;
          end
          else
          begin
            st_d = expander_pkg::S_IDLE;
            sda_oe_d = 1'b0;
          end
        default:
          st_d = st_q;
      endcase
    end
    // Reads clear the transition flags they report (port D1, flags D6); D7 follows port bits
    if (rd_now && ptr_q >= expander_pkg::ADDR_PORT_FIRST && ptr_q <= expander_pkg::ADDR_PORT_LAST)
      trans_d[pidx] = 1'b0;
    if (rd_now && ptr_q == expander_pkg::ADDR_CFG_FLAGS)
      tflag_d = 1'b0;
    // Register writes; reserved and empty slots ignore them
    if (wr_now)
    begin
      if (ptr_q >= expander_pkg::ADDR_PORT_FIRST && ptr_q <= expander_pkg::ADDR_PORT_LAST)
        port_d[pidx] = sh_q;
      else if (ptr_q == expander_pkg::ADDR_CFG_FLAGS)
        flags_d = sh_q[5:0]; // Flags D7 D6 are read-only
      else if (ptr_q == expander_pkg::ADDR_CFG_FUNC)
        func_d = sh_q & expander_pkg::CFG_FUNC_WR_MASK;
    end
    // New transitions win over a clearing read
    for (int k = 0; k < expander_pkg::NUM_PORTS; k++)
      if (trans_ev[k])
      begin
        trans_d[k] = 1'b1;
        tflag_d = 1'b1;
      end
    // Reset pin options
    if (pin_ev && flags_q.tmr_clr)
      blink_d = '0;
    if (pin_ev && flags_q.por_clr)
    begin
      for (int k = 0; k < expander_pkg::NUM_PORTS; k++)
        port_d[k] = expander_pkg::PORT_RESET;
      flags_d = expander_pkg::CFG_FLAGS_RESET[5:0];
      func_d = expander_pkg::CFG_FUNC_RESET;
      trans_d = '0;
      tflag_d = 1'b0;
    end
  end

  // Serial slave and register bank registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= expander_pkg::S_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      ptr_q <= '0;
      rw_q <= 1'b0;
      ack_ok_q <= 1'b0;
      sda_oe_q <= 1'b0;
      for (int k = 0; k < expander_pkg::NUM_PORTS; k++)
        port_q[k] <= expander_pkg::PORT_RESET;
      flags_q <= expander_pkg::CFG_FLAGS_RESET[5:0];
      func_q <= expander_pkg::CFG_FUNC_RESET;
      trans_q <= '0;
      tflag_q <= 1'b0;
      blink_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      ack_ok_q <= ack_ok_d;
      sda_oe_q <= sda_oe_d;
      port_q <= port_d;
      flags_q <= flags_d;
      func_q <= func_d;
      trans_q <= trans_d;
      tflag_q <= tflag_d;
      blink_q <= blink_d;
    end
  end

  // Port drive selection
  always_comb
  begin
    level = 1'b0;
    for (int k = 0; k < expander_pkg::NUM_PORTS; k++)
    begin
      // Output level: nonzero duty, gated by blink phase in blink mode
      level = (|port_q[k].low) && (!port_q[k].mode_b5 || phase);
      out_d[k] = 1'b0;
      oe_d[k] = 1'b0;
      if (k == expander_pkg::P1_IDX && !func_q[expander_pkg::FUNC_P1_GPIO])
        oe_d[k] = irq_pend;
      else if (k == expander_pkg::P3_IDX && !func_q[expander_pkg::FUNC_P3_GPIO])
      begin
        oe_d[k] = 1'b1;
        out_d[k] = blink_q[0];
      end
      else if (port_q[k].is_input || (k == expander_pkg::P2_IDX && !func_q[expander_pkg::FUNC_P2_GPIO]))
        oe_d[k] = 1'b0;
      else if (port_q[k].mode_b6 && k != expander_pkg::P1_IDX)
      begin
        oe_d[k] = 1'b1;
        out_d[k] = level;
      end
      else
        oe_d[k] = !level;
    end
  end

  // Pin driver registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      out_q <= '0;
      oe_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign PORT_OUT = out_q;
  assign PORT_OE = oe_q;
  assign SDA_OE = sda_oe_q;
  assign SDA_OUT = out_q[0] & 1'b0;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_input_no_drive: assert property (port_q[3].is_input |=> !PORT_OE[3])
    else $error("input port driven");
  a_irq_status_low: assert property (trans_ev[1] && port_q[1].mode_b5 && !pin_ev && !wr_now |=> !flags_rd[7])
    else $error("interrupt status not set");
  a_trans_flag_set: assert property ((|trans_ev) && !pin_ev |=> !flags_rd[6])
    else $error("transition flag not set");
  a_port_trans_bit: assert property (trans_ev[3] && !pin_ev |=> trans_q[3] ##1
    (trans_q[3] || $past(rd_now) || $past(pin_ev)))
    else $error("port transition bit lost");
  a_ptr_autoinc: assert property (wr_now |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance");
  a_timer_clear: assert property (pin_ev && flags_q.tmr_clr |=> blink_q == '0)
    else $error("blink counter not cleared");
  a_por_restore: assert property (pin_ev && flags_q.por_clr |=> port_q[2] == expander_pkg::PORT_RESET
    && func_q == expander_pkg::CFG_FUNC_RESET)
    else $error("registers not restored");
  a_irq_pin_drive: assert property (!func_q[expander_pkg::FUNC_P1_GPIO] && irq_pend |=> PORT_OE[0] && !PORT_OUT[0])
    else $error("interrupt pin not driven");
  a_p1_open_drain: assert property (PORT_OE[0] |-> !PORT_OUT[0])
    else $error("first port drove high");
  a_reg_addr_load: assert property (st_q == expander_pkg::S_REG && scl_fall && cnt_q == expander_pkg::BITS_PER_BYTE
    && !start && !stop && s2_q.rst_n |=> ptr_q == $past(sh_q) && sda_oe_q)
    else $error("register address not taken");
endmodule

// [tb/i2c_host_model.sv]
/*
  Host master model for the expander's two-wire register link.
  Assumes the bench resolves SDA from sda_low and the device's drive.
*/
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] SLAVE_ADDR = 7'h4c
) (
  // Clock and resolved data line
  input wire logic clk,
  input wire logic sda,
  // Host drive, SCL stands high between frames
  output logic scl,
  output logic sda_low
);
  // Bus released at time zero
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait whole system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One SCL period: drive in low phase, sample mid high phase
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(2);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(2);
  endtask
  // Start or repeated start: SDA falls while SCL high
  task automatic start_cond();
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
  endtask
  // Stop: SDA rises while SCL high
  task automatic stop_cond();
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  // Byte out, MSB first, returns the device acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, then host acknowledge or not
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  // Single register write, address byte first
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    ok = 1'b0;
    // Reserved places are never written
    if (a == 8'h00 || (a >= 8'h3c && a <= 8'h3f)) return;
    start_cond();
    send_byte({SLAVE_ADDR, 1'b0}, a0);
    send_byte(a, a1);
    send_byte(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // Sequential read of n bytes from address a
  task automatic read_seq(input logic [7:0] a, input int n, output logic [7:0] q [8], output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({SLAVE_ADDR, 1'b0}, a0);
    send_byte(a, a1);
    start_cond();
    send_byte({SLAVE_ADDR, 1'b1}, a2);
    for (int k = 0; k < n; k++)
      recv_byte(k == n - 1, q[k]);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

// [tb/tb.sv]
/*
  Self-checking bench for the four-port expander register block.
  Assumes the host model in tb/i2c_host_model.sv and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  // Clock, resets and pins
  logic clk, rst_n, reset_pin_n, scl, sda_low, sda, sda_out, sda_oe;
  logic [3:0] port_in, port_out, port_oe;
  // Counters and read buffer
  int n_errors = 0, comparisons = 0, cycles = 0;
  logic [7:0] q [8];
  logic ok;
  // Open-drain data line with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  // Device with a short blink counter
  four_port_expander_regs #(.BLINK_BASE(1), .BLINK_W(17)) u_dut (
    .CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .RESET_PIN_N(reset_pin_n), .PORT_IN(port_in), .PORT_OUT(port_out), .PORT_OE(port_oe));
  // Host master
  i2c_host_model #(.SLAVE_ADDR(expander_pkg::SLAVE_ADDR_DEFAULT)) u_host (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Closing report
  task automatic give_verdict();
    $display("errors %0d of %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // Compare one value
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Wait whole clocks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Register write with ack check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d, ok);
    check("write ack", 8'h01, {7'h00, ok});
  endtask
  // Sequential read into q with ack check
  task automatic rd(input logic [7:0] a, input int n);
    u_host.read_seq(a, n, q, ok);
    check("read ack", 8'h01, {7'h00, ok});
  endtask
  // Reset pin low 500 ns, then start setup time
  task automatic pulse_reset_pin();
    reset_pin_n <= 1'b0;
    wait_clk(20);
    reset_pin_n <= 1'b1;
    wait_clk(40);
  endtask
  // Expected {oe, out} of an output port without blink
  function automatic logic [1:0] drive_of(input logic [7:0] v, input logic first);
    logic level;
    level = v[4:0] != 5'h00;
    if (v[6] && !first)
      return {1'b1, level};
    return {~level, 1'b0};
  endfunction
  // Main sequence
  initial
  begin
    logic [7:0] v;
    int k, n;
    logic b;
    rst_n = 1'b0;
    reset_pin_n = 1'b1;
    port_in = 4'h0;
    v = 8'($urandom(32'h8ea445a5));
    wait_clk(6);
    rst_n <= 1'b1;
    wait_clk(4);
    check("oe after reset", 8'h00, {4'h0, port_oe});
    // Map walk with auto-increment
    rd(8'h01, 5);
    for (int i = 0; i < 4; i++)
      check("port reset", 8'h80, q[i]);
    check("gap 05", 8'h00, q[4]);
    rd(8'h26, 3);
    check("flags reset", 8'hec, q[0]);
    check("func reset", 8'h8f, q[1]);
    check("gap 28", 8'h00, q[2]);
    rd(8'h00, 1);
    check("low reserved", 8'h80, q[0]);
    wr(8'h10, 8'h5a);
    rd(8'h10, 1);
    check("unmapped", 8'h00, q[0]);
    // Transition on a port without interrupt enable
    port_in[3] <= 1'b1;
    wait_clk(10);
    rd(8'h26, 1);
    check("flags trans", 8'hac, q[0]);
    rd(8'h26, 1);
    check("flags cleared", 8'hec, q[0]);
    rd(8'h04, 1);
    check("port trans", 8'h83, q[0]);
    rd(8'h04, 1);
    check("port trans clr", 8'h81, q[0]);
    // Enabled transition drives first port as interrupt
    wr(8'h02, 8'ha0);
    wr(8'h27, 8'h8d);
    port_in[1] <= 1'b1;
    wait_clk(10);
    check("irq pin", 8'h02, {6'h00, port_oe[0], port_out[0]});
    rd(8'h26, 1);
    check("flags irq", 8'h2c, q[0]);
    rd(8'h02, 1);
    check("port two trans", 8'ha3, q[0]);
    wr(8'h27, 8'h8f);
    // First port ignores push-pull
    wr(8'h01, 8'h5f);
    wait_clk(2);
    check("first port", {6'h00, drive_of(8'h5f, 1'b1)}, {6'h00, port_oe[0], port_out[0]});
    // Random output settings on the other ports
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h40 : 8'($urandom()) & 8'h5f;
      k = 1 + i % 3;
      wr(8'(k + 1), v);
      wait_clk(2);
      check("port drive", {6'h00, drive_of(v, 1'b0)}, {6'h00, port_oe[k], port_out[k]});
      rd(8'(k + 1), 1);
      check("port readback", v, q[0]);
    end
    // Oscillator functions: second port released, third port driven
    wr(8'h27, 8'h83);
    wait_clk(2);
    check("osc pins", 8'h04, {4'h0, port_oe & 4'h6});
    wr(8'h27, 8'h8f);
    // Blink half period follows the prescaler
    wr(8'h26, 8'h08);
    wr(8'h04, 8'h7f);
    @(negedge clk);
    for (int j = 0; j < 2; j++)
    begin
      b = port_out[3];
      n = 0;
      while (port_out[3] === b && n < 100)
      begin
        @(negedge clk);
        n++;
      end
    end
    check("blink half", 8'h08, 8'(n));
    wait_clk(1);
    // Reset pin without restore keeps registers
    pulse_reset_pin();
    rd(8'h04, 1);
    check("kept", 8'h7f, q[0]);
    // Reset pin with restore and timer clear
    wr(8'h26, 8'h03);
    pulse_reset_pin();
    rd(8'h26, 2);
    check("flags restored", 8'hec, q[0]);
    check("func restored", 8'h8f, q[1]);
    rd(8'h03, 1);
    check("port restored", 8'h80, q[0]);
    check("oe restored", 8'h00, {4'h0, port_oe});
    give_verdict();
  end
endmodule
